// file: sc_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far-side partner: echo line and catchers
// ****************************************
module sc_peer_model (
    input  wire logic       mclk,
    input  wire logic       txdPin,
    input  wire logic       sclkPin,
    output logic            rxdLine,
    output logic      [7:0] uartByte,
    output logic      [7:0] shiftByte
);
    // Loop back; the line follows txdPin directly, with no pull-up
    assign rxdLine = txdPin;
    // Bit changes with each rise; take it one mclk later, once settled
    always @(posedge sclkPin) begin
        @(posedge mclk);
        shiftByte <= {txdPin, shiftByte[7:1]};
    end
    // Frame catcher at bit centres, 32 mclk per bit at fc/2
    initial forever begin
        @(negedge txdPin);
        repeat (16) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (32) @(posedge mclk);
            uartByte[i] = txdPin;
        end
    end
endmodule // sc_peer_model
`default_nettype wire

// file: sc_pkg.sv
`default_nettype none
package sc_pkg;
    // Receiver states, one-hot
    typedef enum logic [4:0] {
        RX_IDLE  = 5'h01,
        RX_START = 5'h02,
        RX_DATA  = 5'h04,
        RX_STOP  = 5'h08,
        RX_WAIT  = 5'h10
    } sc_rx_state_t;
    // Frame format select
    typedef enum logic [1:0] {
        FMT_SHIFT = 2'h0,
        FMT_7     = 2'h1,
        FMT_8     = 2'h2,
        FMT_9     = 2'h3
    } sc_format_t;
    // Serial clock source select
    typedef enum logic [1:0] {
        SRC_TIMER2    = 2'h0,
        SRC_BAUD      = 2'h1,
        SRC_HALF_OSC  = 2'h2,
        SRC_BAUD_HALF = 2'h3
    } sc_clk_src_t;
endpackage
`default_nettype wire

// file: sc_rate_gen.sv
`timescale 1ns/1ps
`default_nettype none
// Prescaler, baud divider and timer 2 feeding the serial base clock
module sc_rate_gen (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic [1:0] rateSel,
    input  wire logic [1:0] clkSrc,
    input  wire logic [7:0] t2Cmp,
    output logic            baseTick
);
    logic [10:0] psc_q, psc_d;
    logic [7:0]  t2_q, t2_d;
    logic        half_q, half_d;
    logic        tick_q, tick_d;
    logic        baudTick, fc8Tick, t2Match;

    // Dividers; a compare value of zero counts 256
    always_comb begin
        psc_d   = psc_q + 11'h001;
        fc8Tick = &psc_q[2:0];
        case (rateSel)
            2'h0:    baudTick = &psc_q[10:0];
            2'h1:    baudTick = &psc_q[8:0];
            2'h2:    baudTick = &psc_q[6:0];
            default: baudTick = &psc_q[4:0];
        endcase
        t2Match = fc8Tick && ((t2_q + 8'h01) == t2Cmp);
        t2_d    = t2Match ? 8'h00 : (fc8Tick ? t2_q + 8'h01 : t2_q);
        half_d  = half_q ^ baudTick;
        case (clkSrc)
            sc_pkg::SRC_TIMER2:   tick_d = t2Match;
            sc_pkg::SRC_BAUD:     tick_d = baudTick;
            sc_pkg::SRC_HALF_OSC: tick_d = psc_q[0];
            default:              tick_d = baudTick & half_q;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            psc_q  <= 11'h000;
            t2_q   <= 8'h00;
            half_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            psc_q  <= psc_d;
            t2_q   <= t2_d;
            half_q <= half_d;
            tick_q <= tick_d;
        end
    end

    assign baseTick = tick_q;
endmodule // sc_rate_gen
`default_nettype wire

// file: sc_regs.svh
`ifndef SC_REGS_SVH
`define SC_REGS_SVH
// ****************************************
// Register offsets on the plain port
// ****************************************
`define SC_ADDR_DATA   3'h0
`define SC_ADDR_MODE   3'h1
`define SC_ADDR_CTRL   3'h2
`define SC_ADDR_RUN    3'h3
`define SC_ADDR_PORT3  3'h4
`define SC_ADDR_T2CMP  3'h5
// ****************************************
// Field positions
// ****************************************
`define SC_MODE_TB8    7
`define SC_MODE_RXE    5
`define SC_MODE_WU     4
`define SC_MODE_SM_HI  3
`define SC_MODE_SM_LO  2
`define SC_MODE_SC_HI  1
`define SC_MODE_SC_LO  0
`define SC_CTRL_RB8    7
`define SC_CTRL_OVERRUN_FLAG   4
`define SC_CTRL_FRAMING_FLAG   2
`define SC_RUN_BR_HI   1
`define SC_RUN_BR_LO   0
`define SC_P3_RXSEL    1
// ****************************************
// Reset values
// ****************************************
`define SC_MODE_RST    8'h00
`define SC_RUN_RST     8'h00
`define SC_P3_RST      8'h00
`define SC_T2_RST      8'h01
// ****************************************
// Timing counts
// ****************************************
`define SC_TICK_LAST   4'hF
`define SC_SMP_FIRST   4'h7
`define SC_SMP_LAST    4'h9
`define SC_DECIDE      4'hA
`define SC_SCLK_RISE   3'h3
`define SC_SCLK_END    3'h7
`define SC_SH_BITS     4'h8
`endif

// file: sc_uart.sv
// Behaviour
// - Transmit and receive buffers are separate and run independently outside shift mode.
// - Shift mode moves one direction at a time over one clock pin.
// - Start bit accepted only if two of three samples are low.
// - Sixteen base ticks per bit, samples at seven to nine, majority wins.
// - Rate select picks prescaler tap fc/2048, fc/512, fc/128 or fc/32.
// - Clock source takes baud output undivided or halved.
// - Clock source may also be fc/2 or timer 2 match.
// - Timer 2 rate is its input clock over sixteen and compare.
// - Shift mode drives a shift clock of fc/8 on its pin.
// - Shift mode samples receive line at each rising shift clock.
// - Shift mode puts one transmit bit out per rising shift clock.
// - Finished character goes to receive buffer with receive interrupt.
// - Unread buffer at completion flags overrun, keeps old, drops new.
// - Overrun and framing flags set in control register.
// - Reading control register clears all error flags together.
// - Ninth received bit stored in control register in 9-bit mode.
// - Wake-up in 9-bit mode interrupts only when ninth bit is one.
// - Transmit counter gives one bit clock every sixteen base ticks.
// - Buffer write starts sending at next transmit bit clock.
// - Data leaves LSB first; stop bit going out raises transmit interrupt.
// - Ninth transmit bit comes from mode register, written first.
// - Stop bit majority of zero flags a framing error.
`timescale 1ns/1ps
`default_nettype none
`include "sc_regs.svh"
module sc_uart (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wrData,
    input  wire logic       wrStb,
    input  wire logic       rdStb,
    output logic      [7:0] rdData,
    input  wire logic       rxdPin,
    output logic            txdPin,
    output logic            sclkPin,
    output logic            transmitIrq,
    output logic            receiveIrq
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [7:0] mode_q, mode_d, run_q, run_d, p3_q, p3_d, t2cmp_q, t2cmp_d;
    logic [7:0] txBuf_q, txBuf_d, rxBuf_q, rxBuf_d, rdData_q, rdData_d, ctrlRd;
    logic       txFull_q, txFull_d, rxFull_q, rxFull_d, rb8_q, rb8_d;
    logic       ovr_q, ovr_d, framing_flag_q, framing_flag_d, rxIrq_q, rxIrq_d, txIrq_q, txIrq_d;
    logic       rxS1_q, rxS2_q, rxLine, baseTick, voteMaj, sampleEn, decide;
    logic       shAct_q, shAct_d, shTx_q, shTx_d, sclk_q, sclk_d;
    logic [2:0] shCnt_q, shCnt_d;
    logic [3:0] shIdx_q, shIdx_d, nBits;
    logic       shRise, shStartTx, shStartRx, shDoneTx;
    logic [9:0] txSh_q, txSh_d;
    logic [3:0] txBits_q, txBits_d, txCnt_q, txCnt_d;
    logic       txd_q, txd_d, bitClk, txLoad;
    logic [8:0] rxSh_q, rxSh_d;
    logic [3:0] rxCnt_q, rxCnt_d, rxIdx_q, rxIdx_d;
    logic       rxDone, rxFerr, rxNinth, accept;
    logic [7:0] rxWord;
    logic       isShift, rxEn, wakeEn;
    sc_pkg::sc_format_t   fmt;
    sc_pkg::sc_rx_state_t rxState_q, rxState_d;

    // Address decode shared by read and write paths
    function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
        return a == off;
    endfunction

    // Data bits per frame for the selected format
    function automatic logic [3:0] frameBits(input sc_pkg::sc_format_t f);
        case (f)
            sc_pkg::FMT_7: return 4'h7;
            sc_pkg::FMT_9: return 4'h9;
            default:       return 4'h8;
        endcase
    endfunction

    assign fmt     = sc_pkg::sc_format_t'(mode_q[`SC_MODE_SM_HI:`SC_MODE_SM_LO]);
    assign isShift = fmt == sc_pkg::FMT_SHIFT;
    assign rxEn    = mode_q[`SC_MODE_RXE];
    assign wakeEn  = mode_q[`SC_MODE_WU];
    assign nBits   = frameBits(fmt);

    // ****************************************
    // Clocking and line sampling
    // ****************************************
    sc_rate_gen u_rate (
        .mclk     (mclk),
        .srst     (srst),
        .rateSel  (run_q[`SC_RUN_BR_HI:`SC_RUN_BR_LO]),
        .clkSrc   (mode_q[`SC_MODE_SC_HI:`SC_MODE_SC_LO]),
        .t2Cmp    (t2cmp_q),
        .baseTick (baseTick)
    );

    // Pin is asynchronous: two stages before anything reads it
    always_ff @(posedge mclk) begin
        if (srst) begin
            rxS1_q <= 1'b1;
            rxS2_q <= 1'b1;
        end else begin
            rxS1_q <= rxdPin;
            rxS2_q <= rxS1_q;
        end
    end

    // Unrouted pin reads as an idle line
    assign rxLine = rxS2_q | ~p3_q[`SC_P3_RXSEL];

    sc_vote u_vote (
        .mclk     (mclk),
        .srst     (srst),
        .sampleEn (sampleEn),
        .din      (rxLine),
        .majority (voteMaj)
    );

    // ****************************************
    // Shift mode sequencer
    // ****************************************
    // Transmit wins over receive; a started transfer runs to its end
    always_comb begin
        shAct_d   = shAct_q;
        shTx_d    = shTx_q;
        shCnt_d   = shCnt_q;
        shIdx_d   = shIdx_q;
        shRise    = shAct_q && (shCnt_q == `SC_SCLK_RISE);
        shStartTx = isShift && !shAct_q && txFull_q;
        shStartRx = isShift && !shAct_q && !txFull_q && rxEn && !rxFull_q;
        shDoneTx  = shAct_q && shTx_q && (shCnt_q == `SC_SCLK_END) && (shIdx_q == `SC_SH_BITS);
        if (shStartTx || shStartRx) begin
            shAct_d = 1'b1;
            shTx_d  = shStartTx;
            shCnt_d = 3'h0;
            shIdx_d = 4'h0;
        end else if (shAct_q) begin
            shCnt_d = shCnt_q + 3'h1;
            if (shRise) begin
                shIdx_d = shIdx_q + 4'h1;
            end
            if ((shCnt_q == `SC_SCLK_END) && (shIdx_q == `SC_SH_BITS)) begin
                shAct_d = 1'b0;
            end
        end
        // Eight mclk per period, idle high
        sclk_d = ~shAct_d | shCnt_d[2];
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            shAct_q <= 1'b0;
            shTx_q  <= 1'b0;
            shCnt_q <= 3'h0;
            shIdx_q <= 4'h0;
            sclk_q  <= 1'b1;
        end else begin
            shAct_q <= shAct_d;
            shTx_q  <= shTx_d;
            shCnt_q <= shCnt_d;
            shIdx_q <= shIdx_d;
            sclk_q  <= sclk_d;
        end
    end

    // ****************************************
    // Transmitter
    // ****************************************
    // Shifter is padded with ones so the stop bit falls out last
    always_comb begin
        txCnt_d  = baseTick ? txCnt_q + 4'h1 : txCnt_q;
        bitClk   = baseTick && (txCnt_q == `SC_TICK_LAST);
        txLoad   = !isShift && bitClk && (txBits_q == 4'h0) && txFull_q;
        txd_d    = txd_q;
        txSh_d   = txSh_q;
        txBits_d = txBits_q;
        txIrq_d  = 1'b0;
        if (shStartTx) begin
            txSh_d = {2'h3, txBuf_q};
        end else if (shRise && shTx_q) begin
            txd_d  = txSh_q[0];
            txSh_d = {1'b1, txSh_q[9:1]};
        end
        // Line back to idle high, else a later frame has no start edge
        if (shDoneTx) begin
            txIrq_d = 1'b1;
            txd_d   = 1'b1;
        end
        if (txLoad) begin
            txd_d    = 1'b0;
            txBits_d = nBits + 4'h1;
            case (fmt)
                sc_pkg::FMT_7: txSh_d = {3'h7, txBuf_q[6:0]};
                sc_pkg::FMT_9: txSh_d = {1'b1, mode_q[`SC_MODE_TB8], txBuf_q};
                default:       txSh_d = {2'h3, txBuf_q};
            endcase
        end else if (bitClk && (txBits_q != 4'h0)) begin
            txd_d    = txSh_q[0];
            txSh_d   = {1'b1, txSh_q[9:1]};
            txBits_d = txBits_q - 4'h1;
            if (txBits_q == 4'h1) begin
                txIrq_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            txCnt_q  <= 4'h0;
            txd_q    <= 1'b1;
            txSh_q   <= 10'h3FF;
            txBits_q <= 4'h0;
            txIrq_q  <= 1'b0;
        end else begin
            txCnt_q  <= txCnt_d;
            txd_q    <= txd_d;
            txSh_q   <= txSh_d;
            txBits_q <= txBits_d;
            txIrq_q  <= txIrq_d;
        end
    end

    // ****************************************
    // Receiver
    // ****************************************
    // Decision one tick after the third sample, when the voter holds all three
    always_comb begin
        rxState_d = rxState_q;
        rxCnt_d   = baseTick ? rxCnt_q + 4'h1 : rxCnt_q;
        rxIdx_d   = rxIdx_q;
        rxSh_d    = rxSh_q;
        rxDone    = 1'b0;
        rxFerr    = 1'b0;
        decide    = baseTick && (rxCnt_q == `SC_DECIDE);
        sampleEn  = baseTick && (rxCnt_q >= `SC_SMP_FIRST) && (rxCnt_q <= `SC_SMP_LAST);
        case (rxState_q)
            sc_pkg::RX_IDLE: begin
                if (!isShift && rxEn && baseTick && !rxLine) begin
                    rxState_d = sc_pkg::RX_START;
                    rxCnt_d   = 4'h1;
                end
            end
            sc_pkg::RX_START: begin
                if (decide) begin
                    rxState_d = voteMaj ? sc_pkg::RX_IDLE : sc_pkg::RX_DATA;
                    rxIdx_d   = 4'h0;
                end
            end
            sc_pkg::RX_DATA: begin
                if (decide) begin
                    rxSh_d  = {voteMaj, rxSh_q[8:1]};
                    rxIdx_d = rxIdx_q + 4'h1;
                    if (rxIdx_q == (nBits - 4'h1)) begin
                        rxState_d = sc_pkg::RX_STOP;
                    end
                end
            end
            sc_pkg::RX_STOP: begin
                if (decide) begin
                    rxDone    = 1'b1;
                    rxFerr    = !voteMaj;
                    rxState_d = sc_pkg::RX_WAIT;
                end
            end
            sc_pkg::RX_WAIT: begin
                if (rxLine) begin
                    rxState_d = sc_pkg::RX_IDLE;
                end
            end
            default: rxState_d = sc_pkg::RX_IDLE;
        endcase
        if (shRise && !shTx_q) begin
            rxSh_d = {rxLine, rxSh_q[8:1]};
            rxDone = shIdx_q == (`SC_SH_BITS - 4'h1);
        end
        case (fmt)
            sc_pkg::FMT_7: rxWord = {1'b0, rxSh_d[8:2]};
            sc_pkg::FMT_9: rxWord = rxSh_d[7:0];
            default:       rxWord = rxSh_d[8:1];
        endcase
        rxNinth = rxSh_d[8];
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rxState_q <= sc_pkg::RX_IDLE;
            rxCnt_q   <= 4'h0;
            rxIdx_q   <= 4'h0;
            rxSh_q    <= 9'h000;
        end else begin
            rxState_q <= rxState_d;
            rxCnt_q   <= rxCnt_d;
            rxIdx_q   <= rxIdx_d;
            rxSh_q    <= rxSh_d;
        end
    end

    // ****************************************
    // Register file and flags
    // ****************************************
    // Flag sets beat same-cycle software clears
    always_comb begin
        mode_d   = (wrStb && hit(addr, `SC_ADDR_MODE))  ? wrData : mode_q;
        run_d    = (wrStb && hit(addr, `SC_ADDR_RUN))   ? wrData : run_q;
        p3_d     = (wrStb && hit(addr, `SC_ADDR_PORT3)) ? wrData : p3_q;
        t2cmp_d  = (wrStb && hit(addr, `SC_ADDR_T2CMP)) ? wrData : t2cmp_q;
        txBuf_d  = (wrStb && hit(addr, `SC_ADDR_DATA))  ? wrData : txBuf_q;
        txFull_d = txFull_q;
        if (txLoad || shStartTx) begin
            txFull_d = 1'b0;
        end
        if (wrStb && hit(addr, `SC_ADDR_DATA)) begin
            txFull_d = 1'b1;
        end
        accept   = rxDone && !rxFull_q;
        rxBuf_d  = accept ? rxWord : rxBuf_q;
        rb8_d    = (accept && (fmt == sc_pkg::FMT_9)) ? rxNinth : rb8_q;
        rxIrq_d  = accept && !((fmt == sc_pkg::FMT_9) && wakeEn && !rxNinth);
        rxFull_d = rxFull_q;
        ovr_d    = ovr_q;
        framing_flag_d   = framing_flag_q;
        if (rdStb && hit(addr, `SC_ADDR_DATA)) begin
            rxFull_d = 1'b0;
        end
        if (rdStb && hit(addr, `SC_ADDR_CTRL)) begin
            ovr_d  = 1'b0;
            framing_flag_d = 1'b0;
        end
        if (accept) begin
            rxFull_d = 1'b1;
        end
        if (rxDone && rxFull_q) begin
            ovr_d = 1'b1;
        end
        if (rxDone && rxFerr) begin
            framing_flag_d = 1'b1;
        end
        ctrlRd                = 8'h00;
        ctrlRd[`SC_CTRL_RB8]  = rb8_q;
        ctrlRd[`SC_CTRL_OVERRUN_FLAG] = ovr_q;
        ctrlRd[`SC_CTRL_FRAMING_FLAG] = framing_flag_q;
        rdData_d = 8'h00;
        if (rdStb) begin
            case (addr)
                `SC_ADDR_DATA:  rdData_d = rxBuf_q;
                `SC_ADDR_MODE:  rdData_d = mode_q;
                `SC_ADDR_CTRL:  rdData_d = ctrlRd;
                `SC_ADDR_RUN:   rdData_d = run_q;
                `SC_ADDR_PORT3: rdData_d = p3_q;
                `SC_ADDR_T2CMP: rdData_d = t2cmp_q;
                default:        rdData_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_q   <= `SC_MODE_RST;
            run_q    <= `SC_RUN_RST;
            p3_q     <= `SC_P3_RST;
            t2cmp_q  <= `SC_T2_RST;
            txBuf_q  <= 8'h00;
            txFull_q <= 1'b0;
            rxBuf_q  <= 8'h00;
            rxFull_q <= 1'b0;
            rb8_q    <= 1'b0;
            ovr_q    <= 1'b0;
            framing_flag_q   <= 1'b0;
            rxIrq_q  <= 1'b0;
            rdData_q <= 8'h00;
        end else begin
            mode_q   <= mode_d;
            run_q    <= run_d;
            p3_q     <= p3_d;
            t2cmp_q  <= t2cmp_d;
            txBuf_q  <= txBuf_d;
            txFull_q <= txFull_d;
            rxBuf_q  <= rxBuf_d;
            rxFull_q <= rxFull_d;
            rb8_q    <= rb8_d;
            ovr_q    <= ovr_d;
            framing_flag_q   <= framing_flag_d;
            rxIrq_q  <= rxIrq_d;
            rdData_q <= rdData_d;
        end
    end

    assign rdData      = rdData_q;
    assign txdPin      = txd_q;
    assign sclkPin     = sclk_q;
    assign transmitIrq = txIrq_q;
    assign receiveIrq  = rxIrq_q;

    // ****************************************
    // Assertions
    // ****************************************
    property p_rx_irq_full;
        @(posedge mclk) disable iff (srst) rxIrq_q |-> rxFull_q;
    endproperty
    a_rx_irq_full: assert property (p_rx_irq_full) else $error("irq without buffered data");

    property p_overrun;
        @(posedge mclk) disable iff (srst) (rxDone && rxFull_q) |=> (ovr_q && $stable(rxBuf_q));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun lost old data");

    property p_err_clear;
        @(posedge mclk) disable iff (srst) (rdStb && hit(addr, `SC_ADDR_CTRL) && !rxDone) |=> (!ovr_q && !framing_flag_q);
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error flags not cleared");

    property p_wakeup;
        @(posedge mclk) disable iff (srst) (rxIrq_q && (fmt == sc_pkg::FMT_9) && wakeEn) |-> rb8_q;
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("wake-up irq with ninth bit low");

    property p_start_reject;
        @(posedge mclk) disable iff (srst) (rxState_q == sc_pkg::RX_START && decide && voteMaj) |=> (rxState_q == sc_pkg::RX_IDLE);
    endproperty
    a_start_reject: assert property (p_start_reject) else $error("noisy start accepted");

    property p_one_dir;
        @(posedge mclk) disable iff (srst) shAct_q |=> $stable(shTx_q) || !$past(shAct_q) || $past(shDoneTx) || !shAct_q;
    endproperty
    a_one_dir: assert property (p_one_dir) else $error("direction changed mid transfer");

    property p_sclk_low;
        @(posedge mclk) disable iff (srst) $fell(sclk_q) |-> !sclk_q[*4] ##1 sclk_q;
    endproperty
    a_sclk_low: assert property (p_sclk_low) else $error("shift clock period wrong");

    property p_start_bit;
        @(posedge mclk) disable iff (srst) txLoad |=> (!txd_q && txBits_q == (nBits + 4'h1));
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit");

    property p_tx_irq_stop;
        @(posedge mclk) disable iff (srst) (txIrq_q && !isShift) |-> (txd_q && txBits_q == 4'h0);
    endproperty
    a_tx_irq_stop: assert property (p_tx_irq_stop) else $error("tx irq not at stop bit");

    property p_framing;
        @(posedge mclk) disable iff (srst) (rxState_q == sc_pkg::RX_STOP && decide && !voteMaj) |=> framing_flag_q;
    endproperty
    a_framing: assert property (p_framing) else $error("framing error missed");

    c_rx_frame: cover property (@(posedge mclk) disable iff (srst) rxIrq_q && !isShift);
    c_overrun: cover property (@(posedge mclk) disable iff (srst) rxDone && rxFull_q);
    c_shift_tx: cover property (@(posedge mclk) disable iff (srst) shDoneTx);
endmodule // sc_uart
`default_nettype wire

// file: sc_vote.sv
`timescale 1ns/1ps
`default_nettype none
// Three-sample majority voter
module sc_vote (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic sampleEn,
    input  wire logic din,
    output logic      majority
);
    logic [2:0] samp_q;
    logic [2:0] samp_d;

    // Keep the last three samples
    always_comb begin
        samp_d = sampleEn ? {samp_q[1:0], din} : samp_q;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            samp_q <= 3'h7;
        end else begin
            samp_q <= samp_d;
        end
    end

    assign majority = (samp_q[0] & samp_q[1]) | (samp_q[0] & samp_q[2]) | (samp_q[1] & samp_q[2]);
endmodule // sc_vote
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bench top
// ****************************************
module tb;
    logic       mclk = 1'b0;
    logic       srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wrData = 8'h00;
    logic       wrStb = 1'b0;
    logic       rdStb = 1'b0;
    logic [7:0] rdData, uartByte, shiftByte;
    logic       txdPin, sclkPin, transmitIrq, receiveIrq, rxdLine;
    logic [1:0] seen;
    int         badCount = 0;
    int         checksDone = 0;
    int         winLen = 480;
    // 40 MHz clock
    initial forever #12.5 mclk = ~mclk;
    sc_uart dut (.mclk(mclk), .srst(srst), .addr(addr), .wrData(wrData), .wrStb(wrStb),
        .rdStb(rdStb), .rdData(rdData), .rxdPin(rxdLine), .txdPin(txdPin), .sclkPin(sclkPin),
        .transmitIrq(transmitIrq), .receiveIrq(receiveIrq));
    sc_peer_model peer (.mclk(mclk), .txdPin(txdPin), .sclkPin(sclkPin), .rxdLine(rxdLine),
        .uartByte(uartByte), .shiftByte(shiftByte));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge mclk);
        wrStb <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rdStb <= 1'b1;
        @(posedge mclk);
        rdStb <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask
    // Window long enough for one 9-bit frame plus bit-clock latency
    task automatic win;
        seen = 2'h0;
        repeat (winLen) begin
            @(posedge mclk);
            #1;
            seen |= {transmitIrq === 1'b1, receiveIrq === 1'b1};
        end
    endtask
    task automatic finishTest;
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Watchdog, the whole run needs about 5000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        badCount++;
        finishTest;
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        rd(3'h1, 8'h00);
        rd(3'h5, 8'h01);
        wr(3'h6, 8'hFF);
        rd(3'h6, 8'h00);
        // Shift mode, transmit only since receive is off
        wr(3'h0, 8'h3C);
        win;
        chk({6'h00, seen}, 8'h02);
        chk(shiftByte, 8'h3C);
        // 8-bit frames at fc/2 looped back
        wr(3'h4, 8'h02);
        wr(3'h1, 8'h2A);
        wr(3'h0, 8'hA5);
        win;
        chk({6'h00, seen}, 8'h03);
        chk(uartByte, 8'hA5);
        rd(3'h2, 8'h00);
        rd(3'h0, 8'hA5);
        // Second frame lands on an unread buffer
        wr(3'h0, 8'h11);
        win;
        wr(3'h0, 8'h22);
        win;
        rd(3'h2, 8'h10);
        rd(3'h2, 8'h00);
        rd(3'h0, 8'h11);
        // Wake-up: ninth bit zero is stored silently
        wr(3'h1, 8'h3E);
        wr(3'h0, 8'h33);
        win;
        chk({6'h00, seen}, 8'h02);
        rd(3'h2, 8'h00);
        rd(3'h0, 8'h33);
        wr(3'h1, 8'hBE);
        wr(3'h0, 8'h5A);
        win;
        chk({6'h00, seen}, 8'h03);
        rd(3'h2, 8'h80);
        rd(3'h0, 8'h5A);
        // Timer 2 match at compare 1: 128 mclk per bit
        winLen = 1800;
        wr(3'h1, 8'h28);
        wr(3'h0, 8'hC3);
        win;
        chk({6'h00, seen}, 8'h03);
        rd(3'h0, 8'hC3);
        finishTest;
    end
endmodule // tb
`default_nettype wire
